//--- rtl/osc_ctrl_pkg.sv
// Purpose: shared constants and types of the oscillator control block
// Assumes: 8-bit register map reached through the two-wire target port
// Notes:   offsets are byte addresses of the target port register pointer
package osc_ctrl_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_TARGET     = 8'h08;
	localparam logic [7:0] OFF_REVISION   = 8'h09;
	localparam logic [7:0] OFF_DEVICE_CONTROL    = 8'h0a;
	localparam logic [7:0] OFF_TRIM_LO    = 8'h10;
	localparam logic [7:0] OFF_TRIM_HI    = 8'h11;
	localparam logic [7:0] OFF_OUT_CTL    = 8'h15;
	localparam logic [7:0] OFF_SOFT_RESET = 8'h48;
	// ==========================================================
	// field positions
	localparam int PDN_BIT     = 6;
	localparam int DEV_RSV_LSB = 2;
	localparam int CAL_BIT     = 1;
	localparam int AUTO_BIT    = 0;
	localparam int SWR_BIT     = 1;
	localparam int OBUF_PD_BIT = 7;
	// ==========================================================
	// values after reset
	localparam logic [4:0] ADDR_HI_RST = 5'h0b;
	localparam logic [7:0] TRIM_HI_RST = 8'h80;
	localparam logic [1:0] OUT_SEL_RST = 2'h1;
	localparam logic       AUTO_RST    = 1'h1;
	// ==========================================================
	// address select encodings
	localparam logic [1:0] ADDR_SEL_LOW   = 2'h0;
	localparam logic [1:0] ADDR_SEL_FLOAT = 2'h1;
	localparam logic [1:0] ADDR_SEL_HIGH  = 2'h2;
	// ==========================================================
	// cycle counts
	localparam logic [1:0] CFG_CYCLES    = 2'h3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// ==========================================================
	// state enumerations
	typedef enum logic [2:0] {
		SEQ_CONFIG,
		SEQ_HALT,
		SEQ_CAL,
		SEQ_LOCK,
		SEQ_RUN,
		SEQ_PDN
	} seq_state_type;
	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ACK_ADDR,
		BUS_PTR,
		BUS_ACK_DATA,
		BUS_WDATA,
		BUS_RDATA,
		BUS_RACK
	} bus_state_type;
endpackage : osc_ctrl_pkg

//--- rtl/i2c_target_port.sv
// Purpose: two-wire target port with register pointer and auto increment
// Assumes: scl_in and sda_in are raw pins; sda is open drain
// Notes:   drives sda low only; changes sda a few cycles after scl falls
`timescale 1ns/1ns
module i2c_target_port
	import osc_ctrl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [6:0] dev_addr_in,
	input  wire logic [7:0] rd_data_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic            wr_stb_out,
	output logic [7:0]      wr_addr_out,
	output logic [7:0]      wr_data_out,
	output logic [7:0]      rd_addr_out
);
	typedef struct packed {
		logic          scl_s1;
		logic          scl_s2;
		logic          scl_p;
		logic          sda_s1;
		logic          sda_s2;
		logic          sda_p;
		bus_state_type st;
		logic [3:0]    cnt;
		logic [7:0]    sh;
		logic [7:0]    ptr;
		logic [7:0]    waddr;
		logic [7:0]    wdata;
		logic          rnw;
		logic          nack;
		logic          oe;
		logic          wstb;
	} port_state_type;

	port_state_type s_q;
	port_state_type s_d;
	logic           rise;
	logic           fall;
	logic           start;
	logic           stop;

	// edges only from the second stage onward, never from the first
	assign rise  = s_q.scl_s2 & ~s_q.scl_p;
	assign fall  = ~s_q.scl_s2 & s_q.scl_p;
	assign start = s_q.scl_s2 & s_q.scl_p & s_q.sda_p & ~s_q.sda_s2;
	assign stop  = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_p & s_q.sda_s2;

	always_comb begin
		s_d        = s_q;
		s_d.wstb   = 1'h0;
		s_d.scl_s1 = scl_in;
		s_d.scl_s2 = s_q.scl_s1;
		s_d.scl_p  = s_q.scl_s2;
		s_d.sda_s1 = sda_in;
		s_d.sda_s2 = s_q.sda_s1;
		s_d.sda_p  = s_q.sda_s2;
		if (start) begin
			s_d.st  = BUS_ADDR;
			s_d.cnt = 4'h0;
			s_d.oe  = 1'h0;
		end else if (stop) begin
			s_d.st = BUS_IDLE;
			s_d.oe = 1'h0;
		end else begin
			case (s_q.st)
				BUS_ADDR, BUS_PTR, BUS_WDATA: begin
					if (rise) begin
						s_d.sh  = {s_q.sh[6:0], s_q.sda_s2};
						s_d.cnt = s_q.cnt + 4'h1;
					end
					if (fall && s_q.cnt == BITS_PER_BYTE) begin
						s_d.cnt = 4'h0;
						s_d.oe  = 1'h1;
						s_d.st  = BUS_ACK_DATA;
						if (s_q.st == BUS_ADDR) begin
							s_d.rnw = s_q.sh[0];
							s_d.st  = BUS_ACK_ADDR;
							// other targets' traffic is ignored
							if (s_q.sh[7:1] != dev_addr_in) begin
								s_d.oe = 1'h0;
								s_d.st = BUS_IDLE;
							end
						end else if (s_q.st == BUS_PTR) begin
							s_d.ptr = s_q.sh;
						end else begin
							s_d.wstb  = 1'h1;
							s_d.waddr = s_q.ptr;
							s_d.wdata = s_q.sh;
							s_d.ptr   = s_q.ptr + 8'h01;
						end
					end
				end
				BUS_ACK_ADDR: begin
					if (fall) begin
						s_d.oe = 1'h0;
						s_d.st = BUS_PTR;
						if (s_q.rnw) begin
							s_d.sh = rd_data_in;
							s_d.oe = ~rd_data_in[7];
							s_d.st = BUS_RDATA;
						end
					end
				end
				BUS_ACK_DATA: begin
					if (fall) begin
						s_d.oe = 1'h0;
						s_d.st = BUS_WDATA;
					end
				end
				BUS_RDATA: begin
					if (rise) begin
						s_d.cnt = s_q.cnt + 4'h1;
					end
					if (fall) begin
						if (s_q.cnt == BITS_PER_BYTE) begin
							s_d.cnt = 4'h0;
							s_d.oe  = 1'h0;
							s_d.ptr = s_q.ptr + 8'h01;
							s_d.st  = BUS_RACK;
						end else begin
							s_d.sh = {s_q.sh[6:0], 1'h0};
							s_d.oe = ~s_q.sh[6];
						end
					end
				end
				BUS_RACK: begin
					if (rise) begin
						s_d.nack = s_q.sda_s2;
					end
					if (fall) begin
						s_d.st = BUS_IDLE;
						if (!s_q.nack) begin
							s_d.sh = rd_data_in;
							s_d.oe = ~rd_data_in[7];
							s_d.st = BUS_RDATA;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sda_out     = 1'h0;
	assign sda_oe_out  = s_q.oe;
	assign wr_stb_out  = s_q.wstb;
	assign wr_addr_out = s_q.waddr;
	assign wr_data_out = s_q.wdata;
	assign rd_addr_out = s_q.ptr;
endmodule : i2c_target_port

//--- rtl/osc_ctrl_regs.sv
// Purpose: control registers and start-up sequencer of the oscillator
// Assumes: cal_done_in, lock_in and nvm inputs are on clk_in
// Notes:   address select pins are synchronised, caught in config phase
// Function
// - target address reads in bits 7..1, bits 7..3 loaded from nvm; port answers it
// - address bits 2..1 are 0, 1, 2 for pin low, floating, high
// - revision record reloads from nvm after reset and after commit
// - power-down clear at reset means synth enabled and calibrated
// - power-down set disables synth and holds calibration in reset
// - power-down cleared re-enables synth and restarts calibration
// - calibration starts on a 0 to 1 write of the trigger bit only
// - trigger bit clears itself when its calibration completes
// - during reset sequence auto start rules, trigger is ignored
// - auto start set: after reset, lock synth then enable outputs
// - power-on reset and soft reset write both restart configuration
// - auto start clear: stop after configuration, no lock, no outputs
// - in halt, writing auto start to 1 begins the lock sequence
// - 10-bit trim offset: bits 9..2 at 0x11, bits 1..0 at 0x10
// - output format 0 tri-state, 1 lvpecl, 2 lvds, 3 hcsl
`timescale 1ns/1ns
module osc_ctrl_regs
	import osc_ctrl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire logic       addr_pin_in,
	input  wire logic       addr_pin_float_in,
	input  wire logic [4:0] nvm_addr_in,
	input  wire logic [7:0] nvm_rev_in,
	input  wire logic       nvm_commit_done_in,
	input  wire logic       cal_done_in,
	input  wire logic       lock_in,
	output logic            synth_enable_out,
	output logic            cal_reset_out,
	output logic            cal_start_out,
	output logic            outputs_enable_out,
	output logic [9:0]      trim_offset_out,
	output logic [1:0]      out_format_out,
	output logic            buffer_power_down_out
);
	// ==========================================================
	// state
	typedef struct packed {
		logic          sel_s1;
		logic          sel_s2;
		logic          flt_s1;
		logic          flt_s2;
		seq_state_type st;
		logic [1:0]    cfg_cnt;
		logic [4:0]    addr_hi;
		logic [1:0]    addr_sel;
		logic [7:0]    rev;
		logic          pdn;
		logic [3:0]    dev_rsv;
		logic          cal;
		logic          auto;
		logic [7:0]    trim_hi;
		logic [1:0]    trim_lo;
		logic          obuf_pd;
		logic [1:0]    out_sel;
		logic          synth_en;
		logic          cal_rst;
		logic          out_en;
		logic          cal_start;
	} ctrl_state_type;

	ctrl_state_type s_q;
	ctrl_state_type s_d;
	logic           wr_stb_w;
	logic [7:0]     wr_addr_w;
	logic [7:0]     wr_data_w;
	logic [7:0]     rd_addr_w;
	logic [7:0]     rd_data_w;
	logic [1:0]     sel_w;
	logic           cfg_last_w;
	logic           dev_wr_w;
	logic           swr_w;
	logic           trig_w;
	logic           auto_rise_w;

	function automatic logic [7:0] reg_read(
		input ctrl_state_type s,
		input logic [7:0]     a
	);
		case (a)
			OFF_TARGET:   reg_read = {s.addr_hi, s.addr_sel, 1'h0};
			OFF_REVISION: reg_read = s.rev;
			OFF_DEVICE_CONTROL:  reg_read = {1'h0, s.pdn, s.dev_rsv, s.cal, s.auto};
			OFF_TRIM_LO:  reg_read = {6'h00, s.trim_lo};
			OFF_TRIM_HI:  reg_read = s.trim_hi;
			OFF_OUT_CTL:  reg_read = {s.obuf_pd, 5'h00, s.out_sel};
			default:      reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// ==========================================================
	// target port
	i2c_target_port u_port (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.dev_addr_in ({s_q.addr_hi, s_q.addr_sel}),
		.rd_data_in  (rd_data_w),
		.sda_out     (sda_out),
		.sda_oe_out  (sda_oe_out),
		.wr_stb_out  (wr_stb_w),
		.wr_addr_out (wr_addr_w),
		.wr_data_out (wr_data_w),
		.rd_addr_out (rd_addr_w)
	);

	assign rd_data_w = reg_read(s_q, rd_addr_w);

	// ==========================================================
	// decode
	assign sel_w = s_q.flt_s2 ? ADDR_SEL_FLOAT :
		(s_q.sel_s2 ? ADDR_SEL_HIGH : ADDR_SEL_LOW);
	assign cfg_last_w = (s_q.st == SEQ_CONFIG) && (s_q.cfg_cnt == CFG_CYCLES);
	assign dev_wr_w = wr_stb_w && (wr_addr_w == OFF_DEVICE_CONTROL);
	assign swr_w = wr_stb_w && (wr_addr_w == OFF_SOFT_RESET) &&
		wr_data_w[SWR_BIT];
	// no trigger while configuring or powered down
	assign trig_w = dev_wr_w && wr_data_w[CAL_BIT] && !s_q.cal &&
		!wr_data_w[PDN_BIT] && (s_q.st != SEQ_CONFIG) &&
		(s_q.st != SEQ_PDN);
	assign auto_rise_w = dev_wr_w && wr_data_w[AUTO_BIT] && !s_q.auto;

	// ==========================================================
	// next state
	always_comb begin
		s_d           = s_q;
		s_d.cal_start = 1'h0;
		s_d.sel_s1    = addr_pin_in;
		s_d.sel_s2    = s_q.sel_s1;
		s_d.flt_s1    = addr_pin_float_in;
		s_d.flt_s2    = s_q.flt_s1;
		if (wr_stb_w) begin
			case (wr_addr_w)
				OFF_DEVICE_CONTROL: begin
					s_d.pdn     = wr_data_w[PDN_BIT];
					s_d.dev_rsv = wr_data_w[DEV_RSV_LSB +: 4];
					s_d.auto    = wr_data_w[AUTO_BIT];
					// a 1 over a pending 1 keeps it, a 0 drops it
					s_d.cal     = s_q.cal & wr_data_w[CAL_BIT];
				end
				OFF_TRIM_LO: s_d.trim_lo = wr_data_w[1:0];
				OFF_TRIM_HI: s_d.trim_hi = wr_data_w;
				OFF_OUT_CTL: begin
					s_d.obuf_pd = wr_data_w[OBUF_PD_BIT];
					s_d.out_sel = wr_data_w[1:0];
				end
				default: begin
				end
			endcase
		end
		case (s_q.st)
			SEQ_CONFIG: begin
				s_d.cal     = 1'h0;
				s_d.cfg_cnt = s_q.cfg_cnt + 2'h1;
				if (cfg_last_w) begin
					s_d.cfg_cnt  = 2'h0;
					s_d.addr_hi  = nvm_addr_in;
					s_d.addr_sel = sel_w;
					s_d.rev      = nvm_rev_in;
					if (s_d.pdn) begin
						s_d.st = SEQ_PDN;
					end else if (s_d.auto) begin
						s_d.st = SEQ_CAL;
					end else begin
						s_d.st = SEQ_HALT;
					end
				end
			end
			SEQ_HALT: begin
				if (auto_rise_w) begin
					s_d.st = SEQ_CAL;
				end
			end
			SEQ_CAL: begin
				if (cal_done_in) begin
					s_d.cal = 1'h0;
					s_d.st  = SEQ_LOCK;
				end
			end
			SEQ_LOCK: begin
				if (lock_in) begin
					s_d.st = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
			end
			SEQ_PDN: begin
				if (!s_d.pdn) begin
					s_d.st = SEQ_CAL;
				end
			end
			default: s_d.st = SEQ_CONFIG;
		endcase
		// a new trigger beats the self clear of the same cycle
		if (trig_w) begin
			s_d.cal = 1'h1;
			s_d.st  = SEQ_CAL;
		end
		if (s_d.pdn && s_q.st != SEQ_CONFIG) begin
			s_d.cal = 1'h0;
			s_d.st  = SEQ_PDN;
		end
		if (swr_w) begin
			s_d.cal     = 1'h0;
			s_d.cfg_cnt = 2'h0;
			s_d.st      = SEQ_CONFIG;
		end
		if (nvm_commit_done_in) begin
			s_d.rev = nvm_rev_in;
		end
		s_d.cal_start = (s_d.st == SEQ_CAL) &&
			((s_q.st != SEQ_CAL) || trig_w);
		s_d.synth_en = (s_d.st == SEQ_CAL) || (s_d.st == SEQ_LOCK) ||
			(s_d.st == SEQ_RUN);
		s_d.cal_rst = (s_d.st == SEQ_PDN);
		s_d.out_en  = (s_d.st == SEQ_RUN);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q         <= '0;
			s_q.addr_hi <= ADDR_HI_RST;
			s_q.auto    <= AUTO_RST;
			s_q.trim_hi <= TRIM_HI_RST;
			s_q.out_sel <= OUT_SEL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	assign synth_enable_out      = s_q.synth_en;
	assign cal_reset_out         = s_q.cal_rst;
	assign cal_start_out         = s_q.cal_start;
	assign outputs_enable_out    = s_q.out_en;
	assign trim_offset_out       = {s_q.trim_hi, s_q.trim_lo};
	assign out_format_out        = s_q.out_sel;
	assign buffer_power_down_out = s_q.obuf_pd;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_cfg_phase;
		(s_q.st == SEQ_CONFIG) [*4];
	endsequence
	sequence s_trig_write;
		dev_wr_w && wr_data_w[CAL_BIT] && !wr_data_w[PDN_BIT] &&
			!s_q.cal && (s_q.st == SEQ_RUN);
	endsequence

	property p_target_read;
		(rd_addr_w == OFF_TARGET) |->
			(rd_data_w[0] == 1'h0) && (rd_data_w[2:1] != 2'h3);
	endproperty
	a_target_read: assert property (p_target_read)
		else $error("target address read wrong");
	property p_sel_map;
		cfg_last_w && !swr_w |=> (s_q.addr_sel == $past(sel_w));
	endproperty
	a_sel_map: assert property (p_sel_map)
		else $error("address select not caught");
	property p_rev_commit;
		nvm_commit_done_in |=> (s_q.rev == $past(nvm_rev_in));
	endproperty
	a_rev_commit: assert property (p_rev_commit)
		else $error("revision not reloaded");
	property p_auto_cal;
		cfg_last_w && !wr_stb_w && !s_q.pdn && s_q.auto |=>
			cal_start_out && synth_enable_out;
	endproperty
	a_auto_cal: assert property (p_auto_cal)
		else $error("no calibration after config");
	property p_pdn_hold;
		s_q.pdn && (s_q.st != SEQ_CONFIG) |->
			cal_reset_out && !synth_enable_out;
	endproperty
	a_pdn_hold: assert property (p_pdn_hold)
		else $error("synth not held down");
	property p_pdn_release;
		$fell(s_q.pdn) && ($past(s_q.st) == SEQ_PDN) &&
			(s_q.st != SEQ_CONFIG) |-> cal_start_out && synth_enable_out;
	endproperty
	a_pdn_release: assert property (p_pdn_release)
		else $error("no restart after power-down");
	property p_trig;
		s_trig_write |=> cal_start_out && s_q.cal;
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger did not start calibration");
	property p_no_fall_trig;
		dev_wr_w && !wr_data_w[CAL_BIT] && !wr_data_w[PDN_BIT] &&
			(s_q.st == SEQ_RUN) |=> !cal_start_out;
	endproperty
	a_no_fall_trig: assert property (p_no_fall_trig)
		else $error("calibration on falling trigger");
	property p_self_clear;
		(s_q.st == SEQ_CAL) && cal_done_in && !wr_stb_w |=>
			!s_q.cal && (s_q.st == SEQ_LOCK);
	endproperty
	a_self_clear: assert property (p_self_clear)
		else $error("trigger bit not self cleared");
	property p_swr_cal;
		swr_w |=> !s_q.cal && !cal_start_out;
	endproperty
	a_swr_cal: assert property (p_swr_cal)
		else $error("trigger acted during reset");
	property p_swreset;
		swr_w |=> s_cfg_phase ##1 (s_q.st != SEQ_CONFIG);
	endproperty
	a_swreset: assert property (p_swreset)
		else $error("soft reset did not rerun config");
	property p_lock;
		(s_q.st == SEQ_LOCK) && lock_in && !wr_stb_w |=> outputs_enable_out;
	endproperty
	a_lock: assert property (p_lock)
		else $error("outputs not enabled on lock");
	property p_halt;
		cfg_last_w && !wr_stb_w && !s_q.auto && !s_q.pdn |=>
			(s_q.st == SEQ_HALT) && !outputs_enable_out && !synth_enable_out;
	endproperty
	a_halt: assert property (p_halt)
		else $error("no halt without auto start");
	property p_halt_go;
		(s_q.st == SEQ_HALT) && dev_wr_w && wr_data_w[AUTO_BIT] &&
			!wr_data_w[PDN_BIT] |=> cal_start_out;
	endproperty
	a_halt_go: assert property (p_halt_go)
		else $error("auto start write did not resume");
	property p_trim;
		wr_stb_w && (wr_addr_w == OFF_TRIM_HI) |=>
			(trim_offset_out[9:2] == $past(wr_data_w));
	endproperty
	a_trim: assert property (p_trim)
		else $error("trim high bits not stored");
	property p_fmt;
		wr_stb_w && (wr_addr_w == OFF_OUT_CTL) |=>
			(out_format_out == $past(wr_data_w[1:0])) &&
			(buffer_power_down_out == $past(wr_data_w[OBUF_PD_BIT]));
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("output control not stored");
endmodule : osc_ctrl_regs

//--- tb/i2c_host_model.sv
// Purpose: two-wire bus host that configures the oscillator block
// Assumes: sda_in is the wire-and level of all pulls, with a pull-up
// Notes:   8 clk per bit; scl stands high between frames
`timescale 1ns/1ns
module i2c_host_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_pull_out
);
	// ==========================================================
	// bit level
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
	endtask : step
	// sda moves one clock after scl falls, never read as start or stop
	task automatic bit_io(input logic b, output logic r);
		step(1);
		sda_pull_out <= ~b;
		step(3);
		scl_out <= 1'b1;
		step(4);
		r = sda_in;
		scl_out <= 1'b0;
	endtask : bit_io
	task automatic start();
		step(1);
		sda_pull_out <= 1'b0;
		step(3);
		scl_out <= 1'b1;
		step(4);
		sda_pull_out <= 1'b1;
		step(4);
		scl_out <= 1'b0;
	endtask : start
	task automatic stop();
		step(1);
		sda_pull_out <= 1'b1;
		step(3);
		scl_out <= 1'b1;
		step(4);
		sda_pull_out <= 1'b0;
		step(4);
	endtask : stop
	// ==========================================================
	// byte level: d=ff releases sda so the device can send
	task automatic byte_io(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, r);
		ack = ~r;
	endtask : byte_io
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a1;
		logic a2;
		logic a3;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, a1);
		byte_io(ptr, 1'b1, q, a2);
		byte_io(d, 1'b1, q, a3);
		stop();
		ok = a1 & a2 & a3;
	endtask : wr
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] q, output logic ok);
		logic [7:0] z;
		logic a1;
		logic a2;
		logic a3;
		start();
		byte_io({dev, 1'b0}, 1'b1, z, a1);
		byte_io(ptr, 1'b1, z, a2);
		start();
		byte_io({dev, 1'b1}, 1'b1, z, a3);
		byte_io(8'hff, 1'b1, q, ok);
		stop();
		ok = a1 & a2 & a3;
	endtask : rd
endmodule : i2c_host_model

//--- tb/oscillator_control_registers_test.sv
// Purpose: self-checking bench of the oscillator control registers
// Assumes: bench stands in for nvm, synthesizer and host
// Notes:   random nvm, trim and buffer power-down values from a fixed seed
`timescale 1ns/1ns
module oscillator_control_registers_test
	import osc_ctrl_pkg::*;
;
	logic       clk_in, rst_n_in, scl, pull, sda, oe, pin, pin_fl;
	logic       commit, cal_done, lock, synth, cal_rst, cal_st, out_en;
	logic       buf_pd, ok, sda_o;
	logic [4:0] nvm_addr;
	logic [7:0] nvm_rev, q, hi, lo, v;
	logic [9:0] trim;
	logic [1:0] fmt;
	int         n_fail = 0, cmp_count = 0, n_cal = 0, seed = 23, c;
	assign sda = ~(pull | oe);
	// ==========================================================
	// design and host
	osc_ctrl_regs u_osc_ctrl_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(oe),
		.addr_pin_in(pin), .addr_pin_float_in(pin_fl),
		.nvm_addr_in(nvm_addr), .nvm_rev_in(nvm_rev),
		.nvm_commit_done_in(commit), .cal_done_in(cal_done),
		.lock_in(lock), .synth_enable_out(synth), .cal_reset_out(cal_rst),
		.cal_start_out(cal_st), .outputs_enable_out(out_en),
		.trim_offset_out(trim), .out_format_out(fmt),
		.buffer_power_down_out(buf_pd));
	i2c_host_model u_i2c_host_model (.clk_in(clk_in), .sda_in(sda),
		.scl_out(scl), .sda_pull_out(pull));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) if (cal_st === 1'b1) n_cal <= n_cal + 1;
	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [9:0] seen,
		input logic [9:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	function automatic logic [6:0] dev();
		return {nvm_addr, pin_fl ? 2'h1 : (pin ? 2'h2 : 2'h0)};
	endfunction : dev
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_i2c_host_model.wr(dev(), a, d, ok);
		chk("wack", 10'(ok), 10'h001);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		u_i2c_host_model.rd(dev(), a, q, ok);
		chk("rack", 10'(ok), 10'h001);
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wait_n
	// the synthesizer stub reports a finished calibration
	task automatic done();
		@(posedge clk_in) cal_done <= 1'b1;
		@(posedge clk_in) cal_done <= 1'b0;
		wait_n(3);
	endtask : done
	task automatic reset_dut();
		@(posedge clk_in) rst_n_in <= 1'b0;
		wait_n(12);
		rst_n_in <= 1'b1;
		wait_n(60);
	endtask : reset_dut
	initial begin
		wait_n(80000);
		n_fail++;
		conclude();
	end
	// ==========================================================
	// scenarios
	initial begin
		{rst_n_in, commit, cal_done, lock, pin, pin_fl} = 6'h00;
		nvm_addr = 5'h0b;
		nvm_rev = 8'h00;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk_in);
			pin <= (s == 2);
			pin_fl <= (s == 1);
			nvm_addr <= 5'($random(seed));
			nvm_rev <= 8'($random(seed));
			c = n_cal;
			reset_dut();
			chk("autocal", 10'(n_cal - c), 10'h001);
			chk("synth", 10'(synth), 10'h001);
			chk("outen", 10'(out_en), 10'h000);
			rd(OFF_TARGET);
			chk("addr", 10'(q[7:1]), 10'(dev()));
			rd(OFF_REVISION);
			chk("rev", 10'(q), 10'(nvm_rev));
		end
		chk("trimrst", trim, 10'h200);
		chk("fmtrst", {7'h00, buf_pd, fmt}, 10'h001);
		rd(OFF_DEVICE_CONTROL);
		chk("devrst", 10'(q), 10'h001);
		done();
		lock <= 1'b1;
		wait_n(3);
		chk("run", 10'(out_en), 10'h001);
		// calibration trigger, then a 1 to 0 write while pending
		c = n_cal;
		wr(OFF_DEVICE_CONTROL, 8'h03);
		chk("trig", 10'(n_cal - c), 10'h001);
		rd(OFF_DEVICE_CONTROL);
		chk("pend", 10'(q[1]), 10'h001);
		wr(OFF_DEVICE_CONTROL, 8'h01);
		chk("fall", 10'(n_cal - c), 10'h001);
		wr(OFF_DEVICE_CONTROL, 8'h03);
		done();
		rd(OFF_DEVICE_CONTROL);
		chk("selfclr", 10'(q[1]), 10'h000);
		chk("rerun", 10'(out_en), 10'h001);
		wr(OFF_DEVICE_CONTROL, 8'h41);
		chk("pdn", {7'h00, cal_rst, synth, out_en}, 10'h004);
		c = n_cal;
		wr(OFF_DEVICE_CONTROL, 8'h01);
		chk("pup", {cal_rst, synth, 8'(n_cal - c)}, 10'h101);
		done();
		// halted start-up, then the host releases it
		wr(OFF_DEVICE_CONTROL, 8'h00);
		nvm_rev <= 8'($random(seed));
		c = n_cal;
		wr(OFF_SOFT_RESET, 8'h02);
		wait_n(60);
		chk("halt", {synth, out_en, 8'(n_cal - c)}, 10'h000);
		rd(OFF_REVISION);
		chk("swrev", 10'(q), 10'(nvm_rev));
		wr(OFF_DEVICE_CONTROL, 8'h01);
		chk("go", {1'b0, synth, 8'(n_cal - c)}, 10'h101);
		done();
		@(posedge clk_in) nvm_rev <= 8'($random(seed));
		commit <= 1'b1;
		@(posedge clk_in) commit <= 1'b0;
		rd(OFF_REVISION);
		chk("commit", 10'(q), 10'(nvm_rev));
		for (int i = 0; i < 4; i++) begin
			hi = (i == 0) ? 8'hff : 8'($random(seed));
			lo = (i == 0) ? 8'h03 : 8'($random(seed));
			wr(OFF_TRIM_HI, hi);
			wr(OFF_TRIM_LO, lo);
			chk("trim", trim, {hi, lo[1:0]});
			rd(OFF_TRIM_HI);
			chk("trimrd", 10'(q), 10'(hi));
		end
		for (int f = 0; f < 4; f++) begin
			v = {1'($random(seed)), 5'h00, 2'(f)};
			wr(OFF_OUT_CTL, v);
			chk("fmt", {7'h00, buf_pd, fmt}, {7'h00, v[7], v[1:0]});
			rd(OFF_OUT_CTL);
			chk("outrd", {7'h00, q[7], q[1:0]}, {7'h00, v[7], v[1:0]});
		end
		wr(OFF_TARGET, 8'h00);
		rd(OFF_TARGET);
		chk("ro", 10'(q[7:1]), 10'(dev()));
		rd(8'h20);
		chk("unmapped", 10'(q), 10'h000);
		u_i2c_host_model.rd(dev() ^ 7'h01, OFF_TARGET, q, ok);
		chk("wrongdev", 10'(ok), 10'h000);
		chk("sdaout", 10'(sda_o), 10'h000);
		conclude();
	end
endmodule : oscillator_control_registers_test
